// ### logic/flse_exec.sv
// flag manipulation and load/store execution unit with register file
// Overview of operation
// - copy register bit into transfer flag
// - write transfer flag into register bit
// - overflow set forces overflow flag high
// - overflow clear forces overflow flag low
// - half carry set forces flag high
// - half carry clear forces flag low
// - sign set forces signed flag high
// - sign clear forces signed flag low
// - post-increment load reads then bumps pointer
// - pre-decrement load drops pointer then reads
// - displaced load uses pointer plus offset
// - direct load reads instruction-given address
// - post-increment store writes then bumps pointer
// - pre-decrement store drops pointer then writes
`timescale 1ns/100ps
`include "flse_cfg.svh"
module flse_exec #(
	parameter int ADDR_W = 16,
	parameter int DISP_W = 6
) (
	input wire logic ref_clk_in, // system clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic instr_valid_in, // instruction presented
	input wire flse_pkg::flse_op_type op_in, // operation
	input wire flse_pkg::flse_mode_type mode_in, // pointer mode
	input wire logic [1:0] ptr_sel_in, // pointer pair select
	input wire logic [4:0] dst_in, // destination register
	input wire logic [4:0] src_in, // source register
	input wire logic [2:0] bit_in, // bit or flag select
	input wire logic [7:0] imm_in, // immediate value
	input wire logic [DISP_W-1:0] disp_in, // displacement
	input wire logic [ADDR_W-1:0] addr_in, // direct address
	input wire logic [7:0] mem_rdata_in, // data memory read data
	input wire logic [4:0] peek_sel_in, // register to observe
	output logic ready_out, // can take an instruction
	output logic [7:0] status_flags_register_out, // status flags register
	output logic [ADDR_W-1:0] mem_addr_out, // data memory address
	output logic [7:0] mem_wdata_out, // data memory write data
	output logic mem_we_out, // data memory write strobe
	output logic mem_re_out, // data memory read strobe
	output logic [7:0] peek_data_out // observed register value
);
	import flse_pkg::*;

	flse_state_type state_reg, state_next;
	logic [7:0] regs_reg [32];
	logic [7:0] regs_next [32];
	logic [7:0] status_flags_register_reg, status_flags_register_next;
	logic [ADDR_W-1:0] mem_addr_reg, mem_addr_next;
	logic [7:0] mem_wdata_reg, mem_wdata_next;
	logic mem_we_reg, mem_we_next;
	logic mem_re_reg, mem_re_next;
	logic [4:0] ld_dst_reg, ld_dst_next;
	logic [7:0] peek_reg, peek_next;

	logic [4:0] ptr_lo;
	logic [4:0] ptr_hi;
	logic [ADDR_W-1:0] ptr_val;
	logic [ADDR_W-1:0] ea;
	logic [ADDR_W-1:0] ptr_new;
	logic ptr_wr;
	logic [4:0] pair_dst;
	logic [4:0] pair_src;
	logic [7:0] ptr_new_lo;
	logic [7:0] ptr_new_hi;
	logic [7:0] swap_val;
	logic [ADDR_W-1:0] disp_addr;

	always_comb begin
		ptr_lo = `FLSE_PTR_Z_LO;
		ptr_hi = `FLSE_PTR_Z_HI;
		if (ptr_sel_in == `FLSE_SEL_X) begin
			ptr_lo = `FLSE_PTR_X_LO;
			ptr_hi = `FLSE_PTR_X_HI;
		end else if (ptr_sel_in == `FLSE_SEL_Y) begin
			ptr_lo = `FLSE_PTR_Y_LO;
			ptr_hi = `FLSE_PTR_Y_HI;
		end
	end

	assign ptr_val = ADDR_W'({regs_reg[ptr_hi], regs_reg[ptr_lo]});
	assign pair_dst = {dst_in[4:1], 1'b0};
	assign pair_src = {src_in[4:1], 1'b0};
	// pointer write-back halves, low byte at the even register
	assign ptr_new_lo = ptr_new[7:0];
	assign ptr_new_hi = 8'(ptr_new >> 8);
	assign swap_val = {regs_reg[dst_in][`FLSE_NIB_LO_TOP:0],
		regs_reg[dst_in][7:`FLSE_NIB_HI_BOT]};
	// displaced form ignores mode_in, so it adds the offset itself
	assign disp_addr = ADDR_W'(ptr_val +
		{{(ADDR_W-DISP_W){1'b0}}, disp_in});

	flse_ptr_calc #(
		.ADDR_W(ADDR_W),
		.DISP_W(DISP_W)
	) u_ptr (
		.ptr_in(ptr_val),
		.mode_in(mode_in),
		.disp_in(disp_in),
		.ea_out(ea),
		.ptr_new_out(ptr_new),
		.ptr_wr_out(ptr_wr)
	);

	always_comb begin
		state_next = state_reg;
		regs_next = regs_reg;
		status_flags_register_next = status_flags_register_reg;
		mem_addr_next = mem_addr_reg;
		mem_wdata_next = mem_wdata_reg;
		mem_we_next = 1'b0;
		mem_re_next = 1'b0;
		ld_dst_next = ld_dst_reg;
		if (state_reg == ST_MEM) begin
			// second clock of a memory access: data lands here
			// a load into its own pointer lands last, so the load wins
			if (mem_re_reg) begin
				regs_next[ld_dst_reg] = mem_rdata_in;
			end
			state_next = ST_IDLE;
		end else if (instr_valid_in) begin
			unique case (op_in)
				OP_SWAP: begin
					regs_next[dst_in] = swap_val;
				end
				OP_FLAG_RAISE: status_flags_register_next[bit_in] = 1'b1;
				OP_FLAG_LOWER: status_flags_register_next[bit_in] = 1'b0;
				OP_BIT_TO_TRANSFER_FLAG: begin
					status_flags_register_next[`FLSE_FLAG_T] = regs_reg[src_in][bit_in];
				end
				OP_TRANSFER_FLAG_TO_BIT: begin
					regs_next[dst_in][bit_in] = status_flags_register_reg[`FLSE_FLAG_T];
				end
				OP_OVERFLOW_FLAG_SET: status_flags_register_next[`FLSE_FLAG_V] = 1'b1;
				OP_OVERFLOW_FLAG_CLEAR: status_flags_register_next[`FLSE_FLAG_V] = 1'b0;
				OP_HALF_CARRY_SET: status_flags_register_next[`FLSE_FLAG_H] = 1'b1;
				OP_HALF_CARRY_CLEAR: status_flags_register_next[`FLSE_FLAG_H] = 1'b0;
				OP_SIGN_FLAG_SET: status_flags_register_next[`FLSE_FLAG_S] = 1'b1;
				OP_SIGN_FLAG_CLEAR: status_flags_register_next[`FLSE_FLAG_S] = 1'b0;
				OP_REGISTER_COPY: regs_next[dst_in] = regs_reg[src_in];
				OP_REGISTER_PAIR_COPY: begin
					regs_next[pair_dst] = regs_reg[pair_src];
					regs_next[pair_dst | 5'h01] = regs_reg[pair_src | 5'h01];
				end
				OP_IMMEDIATE_LOAD: regs_next[dst_in] = imm_in;
				OP_INDIRECT_LOAD, OP_INDIRECT_WRITE: begin
					// pointer is written back now; the access uses ea, worked out from the old pointer
					mem_addr_next = ea;
					if (ptr_wr) begin
						regs_next[ptr_lo] = ptr_new_lo;
						regs_next[ptr_hi] = ptr_new_hi;
					end
					mem_re_next = (op_in == OP_INDIRECT_LOAD);
					mem_we_next = (op_in == OP_INDIRECT_WRITE);
					mem_wdata_next = regs_reg[src_in];
					ld_dst_next = dst_in;
					state_next = ST_MEM;
				end
				OP_DISPLACED_LOAD: begin
					// X, Y and Z all take a displacement here, chosen by ptr_sel_in
					mem_addr_next = disp_addr;
					mem_re_next = 1'b1;
					ld_dst_next = dst_in;
					state_next = ST_MEM;
				end
				OP_DIRECT_LOAD: begin
					mem_addr_next = addr_in;
					mem_re_next = 1'b1;
					ld_dst_next = dst_in;
					state_next = ST_MEM;
				end
				default: begin
					// unused op codes retire as a one-clock no-op
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state_reg <= ST_IDLE;
			for (int i = 0; i < 32; i++) begin
				regs_reg[i] <= `FLSE_REG_RESET;
			end
			status_flags_register_reg <= `FLSE_STATUS_FLAGS_REGISTER_RESET;
			mem_addr_reg <= `FLSE_ADDR_RESET;
			mem_wdata_reg <= `FLSE_REG_RESET;
			mem_we_reg <= 1'b0;
			mem_re_reg <= 1'b0;
			ld_dst_reg <= 5'h00;
		end else begin
			state_reg <= state_next;
			regs_reg <= regs_next;
			status_flags_register_reg <= status_flags_register_next;
			mem_addr_reg <= mem_addr_next;
			mem_wdata_reg <= mem_wdata_next;
			mem_we_reg <= mem_we_next;
			mem_re_reg <= mem_re_next;
			ld_dst_reg <= ld_dst_next;
		end
	end

	// observation port: its own group, never disturbs execution
	always_comb begin
		peek_next = regs_reg[peek_sel_in];
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			peek_reg <= `FLSE_REG_RESET;
		end else begin
			peek_reg <= peek_next;
		end
	end

	// no queue: valid is ignored while a memory access is in flight
	assign ready_out = (state_reg == ST_IDLE);
	assign status_flags_register_out = status_flags_register_reg;
	assign mem_addr_out = mem_addr_reg;
	assign mem_wdata_out = mem_wdata_reg;
	assign mem_we_out = mem_we_reg;
	assign mem_re_out = mem_re_reg;
	assign peek_data_out = peek_reg;
endmodule

// ### logic/flse_cfg.svh
// constants for the flag and load/store execution block
`ifndef FLSE_CFG_SVH
`define FLSE_CFG_SVH

// status flag bit positions
`define FLSE_FLAG_C 3'h0
`define FLSE_FLAG_Z 3'h1
`define FLSE_FLAG_N 3'h2
`define FLSE_FLAG_V 3'h3
`define FLSE_FLAG_S 3'h4
`define FLSE_FLAG_H 3'h5
`define FLSE_FLAG_T 3'h6
`define FLSE_FLAG_I 3'h7

// pointer register pairs, low byte then high byte
`define FLSE_PTR_X_LO 5'h1A
`define FLSE_PTR_X_HI 5'h1B
`define FLSE_PTR_Y_LO 5'h1C
`define FLSE_PTR_Y_HI 5'h1D
`define FLSE_PTR_Z_LO 5'h1E
`define FLSE_PTR_Z_HI 5'h1F

// pointer select codes
`define FLSE_SEL_X 2'h0
`define FLSE_SEL_Y 2'h1
`define FLSE_SEL_Z 2'h2

// reset values
`define FLSE_STATUS_FLAGS_REGISTER_RESET 8'h00
`define FLSE_REG_RESET 8'h00
`define FLSE_ADDR_RESET 16'h0000

// nibble field bounds
`define FLSE_NIB_LO_TOP 3
`define FLSE_NIB_HI_BOT 4

`endif

// ### logic/flse_pkg.sv
// types shared by the flag and load/store execution block
package flse_pkg;

	typedef enum logic [4:0] {
		OP_SWAP,
		OP_FLAG_RAISE,
		OP_FLAG_LOWER,
		OP_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_BIT,
		OP_OVERFLOW_FLAG_SET,
		OP_OVERFLOW_FLAG_CLEAR,
		OP_HALF_CARRY_SET,
		OP_HALF_CARRY_CLEAR,
		OP_SIGN_FLAG_SET,
		OP_SIGN_FLAG_CLEAR,
		OP_REGISTER_COPY,
		OP_REGISTER_PAIR_COPY,
		OP_IMMEDIATE_LOAD,
		OP_INDIRECT_LOAD,
		OP_DISPLACED_LOAD,
		OP_DIRECT_LOAD,
		OP_INDIRECT_WRITE
	} flse_op_type;

	typedef enum logic [1:0] {
		AM_PLAIN,
		AM_POST_INC,
		AM_PRE_DEC,
		AM_DISP
	} flse_mode_type;

	typedef enum logic {
		ST_IDLE,
		ST_MEM
	} flse_state_type;

endpackage

// ### logic/flse_ptr_calc.sv
// pointer arithmetic: effective address and updated pointer value
`timescale 1ns/100ps
module flse_ptr_calc #(
	parameter int ADDR_W = 16,
	parameter int DISP_W = 6
) (
	input wire logic [ADDR_W-1:0] ptr_in, // current pointer value
	input wire flse_pkg::flse_mode_type mode_in, // addressing mode
	input wire logic [DISP_W-1:0] disp_in, // unsigned displacement
	output logic [ADDR_W-1:0] ea_out, // address presented to memory
	output logic [ADDR_W-1:0] ptr_new_out, // value written back
	output logic ptr_wr_out // pointer must be written back
);
	import flse_pkg::*;

	logic [ADDR_W-1:0] inc_val;
	logic [ADDR_W-1:0] dec_val;
	logic [ADDR_W-1:0] disp_val;

	// pointers wrap at the top of the address space
	assign inc_val = ADDR_W'(ptr_in + 1'b1);
	assign dec_val = ADDR_W'(ptr_in - 1'b1);
	assign disp_val = ADDR_W'(ptr_in + {{(ADDR_W-DISP_W){1'b0}}, disp_in});

	always_comb begin
		ea_out = ptr_in;
		ptr_new_out = ptr_in;
		ptr_wr_out = 1'b0;
		unique case (mode_in)
			AM_PLAIN: begin
				ea_out = ptr_in;
			end
			AM_POST_INC: begin
				ea_out = ptr_in;
				ptr_new_out = inc_val;
				ptr_wr_out = 1'b1;
			end
			AM_PRE_DEC: begin
				ea_out = dec_val;
				ptr_new_out = dec_val;
				ptr_wr_out = 1'b1;
			end
			AM_DISP: begin
				ea_out = disp_val;
			end
		endcase
	end
endmodule

// ### tb/flse_mem_model.sv
// data memory model seen by the flag and load/store unit
`timescale 1ns/100ps
module flse_mem_model (
	input wire logic clk_in, // system clock
	input wire logic [15:0] addr_in, // address, low byte decoded
	input wire logic [7:0] wdata_in, // write data
	input wire logic we_in, // write strobe
	input wire logic re_in, // read strobe
	output logic [7:0] rdata_out // combinational read data
);
	logic [7:0] mem [256];
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
	always @(posedge clk_in) if (we_in) mem[addr_in[7:0]] <= wdata_in;
	// off the strobe the bus shows inverted data so a late sample is caught
	assign rdata_out = re_in ? mem[addr_in[7:0]] : ~mem[addr_in[7:0]];
endmodule

// ### tb/flse_exec_chk.sv
// port assertions for the flag and load/store unit
`timescale 1ns/100ps
`include "flse_cfg.svh"
module flse_exec_chk #(
	parameter int ADDR_W = 16
) (
	input wire logic ref_clk_in, // clock
	input wire logic rst_n_in, // reset, active low
	input wire logic instr_valid_in, // instruction valid
	input wire flse_pkg::flse_op_type op_in, // operation
	input wire logic [ADDR_W-1:0] addr_in, // direct address
	input wire logic ready_out, // idle
	input wire logic [7:0] status_flags_register_out, // status flags
	input wire logic [ADDR_W-1:0] mem_addr_out, // memory address
	input wire logic mem_we_out, // write strobe
	input wire logic mem_re_out // read strobe
);
	import flse_pkg::*;
	logic take;
	assign take = instr_valid_in && ready_out;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_mem_busy;
		(mem_re_out ^ mem_we_out) && !ready_out
		##1 ready_out && !mem_re_out && !mem_we_out;
	endsequence
	property p_flag(flse_op_type o, int b, logic v);
		take && op_in == o |=> status_flags_register_out[b] == v &&
			((status_flags_register_out ^ $past(status_flags_register_out)) & ~(8'h01 << b)) == 8'h00;
	endproperty
	a_mem_two_clk: assert property (
		take && op_in >= OP_INDIRECT_LOAD |=> s_mem_busy)
		else $error("memory op not two clocks");
	a_strobe_kind: assert property (
		take && op_in >= OP_INDIRECT_LOAD |=>
		mem_we_out == ($past(op_in) == OP_INDIRECT_WRITE))
		else $error("wrong memory strobe");
	a_direct_addr: assert property (
		take && op_in == OP_DIRECT_LOAD |=> mem_addr_out == $past(addr_in))
		else $error("direct address wrong");
	a_one_clk: assert property (
		take && op_in < OP_INDIRECT_LOAD |=> ready_out && !mem_re_out)
		else $error("one clock op stalled");
	a_flags_kept: assert property (
		take && (op_in inside {OP_SWAP, OP_TRANSFER_FLAG_TO_BIT,
		OP_REGISTER_COPY, OP_REGISTER_PAIR_COPY, OP_IMMEDIATE_LOAD} ||
		op_in >= OP_INDIRECT_LOAD) |=> $stable(status_flags_register_out))
		else $error("flags changed");
	a_t_only: assert property (
		take && op_in == OP_BIT_TO_TRANSFER_FLAG |=>
		((status_flags_register_out ^ $past(status_flags_register_out)) & 8'hBF) == 8'h00)
		else $error("flag other than transfer changed");
	a_ovf_set: assert property (
		p_flag(OP_OVERFLOW_FLAG_SET, `FLSE_FLAG_V, 1'b1))
		else $error("overflow set wrong");
	a_ovf_clear: assert property (
		p_flag(OP_OVERFLOW_FLAG_CLEAR, `FLSE_FLAG_V, 1'b0))
		else $error("overflow clear wrong");
	a_half_set: assert property (
		p_flag(OP_HALF_CARRY_SET, `FLSE_FLAG_H, 1'b1))
		else $error("half carry set wrong");
	a_half_clear: assert property (
		p_flag(OP_HALF_CARRY_CLEAR, `FLSE_FLAG_H, 1'b0))
		else $error("half carry clear wrong");
	a_sign_set: assert property (
		p_flag(OP_SIGN_FLAG_SET, `FLSE_FLAG_S, 1'b1))
		else $error("sign set wrong");
	a_sign_clear: assert property (
		p_flag(OP_SIGN_FLAG_CLEAR, `FLSE_FLAG_S, 1'b0))
		else $error("sign clear wrong");
endmodule
bind flse_exec flse_exec_chk #(.ADDR_W(ADDR_W)) u_chk (.ref_clk_in,
	.rst_n_in, .instr_valid_in, .op_in, .addr_in, .ready_out, .status_flags_register_out,
	.mem_addr_out, .mem_we_out, .mem_re_out);

// ### tb/testbench.sv
// random and corner-case bench for the flag and load/store unit
`timescale 1ns/100ps
`include "flse_cfg.svh"
module testbench;
	import flse_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic vld = 1'b0;
	flse_op_type op = OP_SWAP;
	flse_mode_type md = AM_PLAIN;
	logic [1:0] sel = 2'h0;
	logic [4:0] dst = 5'h00;
	logic [4:0] src = 5'h00;
	logic [4:0] pk = 5'h00;
	logic [2:0] bt = 3'h0;
	logic [7:0] imm = 8'h00;
	logic [5:0] dsp = 6'h00;
	logic [15:0] ad = 16'h0000;
	logic [7:0] rd, sr, wd, pd, s;
	logic [15:0] ma, ea;
	logic rdy, we, re;
	logic [7:0] r [32];
	logic [7:0] m [256];
	int seed = 53138;
	int mismatches = 0;
	int cmp_count = 0;
	always #10 clk = ~clk;
	flse_exec uut (.ref_clk_in(clk), .rst_n_in(rst_n), .instr_valid_in(vld),
		.op_in(op), .mode_in(md), .ptr_sel_in(sel), .dst_in(dst),
		.src_in(src), .bit_in(bt), .imm_in(imm), .disp_in(dsp),
		.addr_in(ad), .mem_rdata_in(rd), .peek_sel_in(pk), .ready_out(rdy),
		.status_flags_register_out(sr), .mem_addr_out(ma), .mem_wdata_out(wd),
		.mem_we_out(we), .mem_re_out(re), .peek_data_out(pd));
	flse_mem_model u_mem (.clk_in(clk), .addr_in(ma), .wdata_in(wd),
		.we_in(we), .re_in(re), .rdata_out(rd));
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic void model();
		logic [4:0] lo;
		logic [15:0] p;
		lo = 5'h1A + {(sel == 2'h3) ? 2'h2 : sel, 1'b0};
		p = {r[lo + 1], r[lo]};
		ea = p + 16'(dsp);
		case (op)
			OP_SWAP: r[dst] = {r[dst][3:0], r[dst][7:4]};
			OP_FLAG_RAISE: s[bt] = 1'b1;
			OP_FLAG_LOWER: s[bt] = 1'b0;
			OP_BIT_TO_TRANSFER_FLAG: s[`FLSE_FLAG_T] = r[src][bt];
			OP_TRANSFER_FLAG_TO_BIT: r[dst][bt] = s[`FLSE_FLAG_T];
			OP_OVERFLOW_FLAG_SET: s[`FLSE_FLAG_V] = 1'b1;
			OP_OVERFLOW_FLAG_CLEAR: s[`FLSE_FLAG_V] = 1'b0;
			OP_HALF_CARRY_SET: s[`FLSE_FLAG_H] = 1'b1;
			OP_HALF_CARRY_CLEAR: s[`FLSE_FLAG_H] = 1'b0;
			OP_SIGN_FLAG_SET: s[`FLSE_FLAG_S] = 1'b1;
			OP_SIGN_FLAG_CLEAR: s[`FLSE_FLAG_S] = 1'b0;
			OP_REGISTER_COPY: r[dst] = r[src];
			OP_REGISTER_PAIR_COPY: {r[dst | 5'h01], r[dst & 5'h1E]} =
				{r[src | 5'h01], r[src & 5'h1E]};
			OP_IMMEDIATE_LOAD: r[dst] = imm;
			OP_DIRECT_LOAD: ea = ad;
			OP_DISPLACED_LOAD: ;
			default: begin
				p = p - 16'(md == AM_PRE_DEC);
				if (md != AM_DISP) ea = p;
				{r[lo + 1], r[lo]} = p + 16'(md == AM_POST_INC);
			end
		endcase
		if (op == OP_INDIRECT_WRITE) m[ea[7:0]] = r[src];
		else if (op >= OP_INDIRECT_LOAD) r[dst] = m[ea[7:0]];
	endfunction
	// valid stays high so ops run back to back; the busy clock is ignored
	task automatic run();
		model();
		vld = 1'b1;
		@(posedge clk);
		#1;
		if (op >= OP_INDIRECT_LOAD) begin
			chk("busy", 16'h0000, 16'(rdy));
			@(posedge clk);
			#1;
			chk("addr", ea, ma);
		end
		chk("ready", 16'h0001, 16'(rdy));
		if (op == OP_INDIRECT_WRITE) chk("wdata", 16'(r[src]), 16'(wd));
		chk("flags", 16'(s), 16'(sr));
	endtask
	task automatic print_verdict();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end
	initial begin
		int n;
		for (int i = 0; i < 256; i++) m[i] = 8'(i * 37 + 5);
		r = '{default: `FLSE_REG_RESET};
		s = `FLSE_STATUS_FLAGS_REGISTER_RESET;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		// pointer at zero so pre-decrement wraps and post-increment wraps back
		op = OP_IMMEDIATE_LOAD;
		dst = 5'h1B;
		run();
		op = OP_INDIRECT_LOAD;
		md = AM_PRE_DEC;
		dst = 5'h03;
		run();
		op = OP_INDIRECT_WRITE;
		md = AM_POST_INC;
		src = 5'h03;
		run();
		op = OP_DISPLACED_LOAD;
		sel = 2'h1;
		dsp = 6'h3F;
		run();
		repeat (400) begin
			op = flse_op_type'(5'($unsigned($random(seed)) % 18));
			n = (op >= OP_INDIRECT_LOAD) ? 26 : 32;
			dst = 5'($unsigned($random(seed)) % n);
			src = 5'($unsigned($random(seed)) % n);
			md = flse_mode_type'(2'($random(seed)));
			{bt, imm, dsp, sel} = 19'($random(seed));
			ad = 16'($random(seed));
			run();
		end
		vld = 1'b0;
		for (int i = 0; i < 32; i++) begin
			pk = 5'(i);
			@(posedge clk);
			#1;
			chk("reg", 16'(r[i]), 16'(pd));
		end
		print_verdict();
	end
endmodule
